//--- inc/drive_pkg.sv
// constants, field layout and types shared by the drive sequencer source logic
package drive_pkg;

	// ************************************************
	// clock and timing
	// ************************************************
	localparam int unsigned CLK_HZ         = 50_000_000;
	localparam int unsigned SEQ_TICK_MS    = 4;
	localparam int unsigned SEQ_TICK_CYC   = CLK_HZ / 1000 * SEQ_TICK_MS;
	localparam int unsigned BG_TICK_US     = 1000;
	localparam int unsigned BG_TICK_CYC    = CLK_HZ / 1_000_000 * BG_TICK_US;

	// ************************************************
	// register byte offsets
	// ************************************************
	localparam logic [7:0] OFF_CMD_WORD    = 8'h00;
	localparam logic [7:0] OFF_CMD_EN      = 8'h04;
	localparam logic [7:0] OFF_SEQ_PARAMS  = 8'h08;
	localparam logic [7:0] OFF_EVENT_FLAGS = 8'h0C;
	localparam logic [7:0] OFF_INT_MASK    = 8'h10;
	localparam logic [7:0] OFF_SEQ_STATUS  = 8'h14;

	// ************************************************
	// command word bit mapping
	// ************************************************
	localparam int CW_DRIVE_EN   = 0;
	localparam int CW_RUN_FWD    = 1;
	localparam int CW_JOG        = 2;
	localparam int CW_RUN_REV    = 3;
	localparam int CW_DIR_SEL    = 4;
	localparam int CW_RUN        = 5;
	localparam int CW_NOT_STOP   = 6;
	localparam int CW_AUTO       = 7;
	localparam int CW_REF_SEL    = 8;
	localparam int CW_JOG_REV    = 9;
	// reserved bits 10, 11 and the top bit are never stored
	localparam logic [15:0] CW_STORE_MASK = 16'h73FF;

	// ************************************************
	// individual sequencing parameter layout
	// ************************************************
	localparam int SP_DRIVE_EN   = 0;
	localparam int SP_RUN_FWD    = 1;
	localparam int SP_INCH       = 2;
	localparam int SP_RUN_REV    = 3;
	localparam int SP_DIR_SEL    = 4;
	localparam int SP_RUN_REQ    = 5;
	localparam int SP_KEEP_RUN   = 6;
	localparam int SP_JOG_BACK   = 7;
	localparam int SP_LATCH_EN   = 8;
	localparam int SP_W          = 9;

	// ************************************************
	// event flag bits and reset values
	// ************************************************
	localparam int EF_DEFAULTS   = 0;
	localparam int EF_MODE_CHG   = 1;
	localparam int EF_W          = 16;
	localparam logic [15:0] CMD_WORD_RST = 16'h0000;
	localparam logic [15:0] FLAGS_RST    = 16'h0000;
	localparam logic [SP_W-1:0] SP_RST   = 9'h000;

	// ************************************************
	// types
	// ************************************************
	typedef enum logic [1:0] {
		MODE_OPEN_LOOP,
		MODE_CLOSED_LOOP,
		MODE_SERVO,
		MODE_REGEN
	} drive_mode_t;

endpackage

//--- logic/drive_seq_sources.sv
// sequencer source selection, limit switch direction logic and event flags
//
// What this block does
// - closed loop: limits follow reference plus hard speed
// - flag bit 0 after defaults and save
// - flag bit 1 after mode change and save
// - flags cleared only by reset or software
// - command word ignored while its enable is zero
// - fixed command word bit mapping
// - word bits drive sequencer when enable and auto
// - individual parameters kept, merely ignored
// - otherwise individual parameters drive the sequencer
// - regen mode ignores starred word bits
// - low byte on 4 ms tick, high background
// - flag word 16 bits, resets to zero
// - command word top bit never set
// - open loop: limits follow pre-ramp reference sign
// - run latches cleared while not-stop is zero
// - active limit stops its own direction only
`timescale 1ns/1ns
module drive_seq_sources #(
	parameter int unsigned SEQ_TICK_CYCLES = drive_pkg::SEQ_TICK_CYC,
	parameter int unsigned BG_TICK_CYCLES  = drive_pkg::BG_TICK_CYC,
	parameter int unsigned REF_W           = 32
) (
	// clock and reset
	input  wire logic               sys_clk,
	input  wire logic               resetn,
	// apb slave
	input  wire logic               psel,
	input  wire logic               penable,
	input  wire logic               pwrite,
	input  wire logic [7:0]         paddr,
	input  wire logic [31:0]        pwdata,
	output logic [31:0]             prdata,
	output logic                    pready,
	output logic                    pslverr,
	output logic                    irq,
	// drive state
	input  drive_pkg::drive_mode_t  driveMode,
	input  wire logic signed [REF_W-1:0] preRampRef,
	input  wire logic signed [REF_W-1:0] hardSpeedRef,
	input  wire logic               fwdLimitSwitch,
	input  wire logic               revLimitSwitch,
	// drive events
	input  wire logic               defaultsLoaded,
	input  wire logic               modeChanged,
	input  wire logic               paramSaveDone,
	// sequencer sources
	output logic                    driveEnable,
	output logic                    runFwd,
	output logic                    jog,
	output logic                    runRev,
	output logic                    dirSelect,
	output logic                    runRequest,
	output logic                    notStop,
	output logic                    jogBackward,
	output logic                    refSelect,
	// limit switches
	output logic                    fwdLimitEnable,
	output logic                    revLimitEnable,
	output logic                    fwdStop,
	output logic                    revStop
);
	if (SEQ_TICK_CYCLES < 2 || BG_TICK_CYCLES < 2 || REF_W < 2) begin : g_bad_param
		$error("tick counts need at least 2 cycles, reference at least 2 bits");
	end

	localparam int SEQ_CW = $clog2(SEQ_TICK_CYCLES);
	localparam int BG_CW  = $clog2(BG_TICK_CYCLES);
	localparam logic [SEQ_CW-1:0] SEQ_LAST = SEQ_CW'(SEQ_TICK_CYCLES - 1);
	localparam logic [BG_CW-1:0]  BG_LAST  = BG_CW'(BG_TICK_CYCLES - 1);

	// ************************************************
	// reset release
	// ************************************************
	logic rstSync1_q;
	logic rstN;

	always_ff @(posedge sys_clk or negedge resetn) begin
		if (!resetn) begin
			rstSync1_q <= 1'b0;
			rstN       <= 1'b0;
		end else begin
			rstSync1_q <= 1'b1;
			rstN       <= rstSync1_q;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rstN);

	// ************************************************
	// tick dividers
	// ************************************************
	logic [SEQ_CW-1:0] seqCnt_q;
	logic [BG_CW-1:0]  bgCnt_q;
	logic              seqTick;
	logic              bgTick;

	assign seqTick = (seqCnt_q == SEQ_LAST);
	assign bgTick  = (bgCnt_q == BG_LAST);

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			seqCnt_q <= '0;
			bgCnt_q  <= '0;
		end else begin
			seqCnt_q <= seqTick ? '0 : seqCnt_q + 1'b1;
			bgCnt_q  <= bgTick ? '0 : bgCnt_q + 1'b1;
		end
	end

	// ************************************************
	// apb slave and registers
	// ************************************************
	logic [15:0]                cmdWord_q;
	logic                       cmdEn_q;
	logic [drive_pkg::SP_W-1:0] seqParams_q;
	logic [15:0]                flags_q;
	logic [15:0]                mask_q;
	logic [15:0]                seqStatus;
	logic                       setup;
	logic                       wrAcc;
	logic                       flagsWr;
	logic [15:0]                flagsSet;
	logic                       mapped;

	assign setup   = psel && !penable;
	assign wrAcc   = psel && penable && pready && pwrite;
	assign flagsWr = wrAcc && (paddr == drive_pkg::OFF_EVENT_FLAGS);
	assign mapped  = (paddr == drive_pkg::OFF_CMD_WORD) || (paddr == drive_pkg::OFF_CMD_EN)
		|| (paddr == drive_pkg::OFF_SEQ_PARAMS) || (paddr == drive_pkg::OFF_EVENT_FLAGS)
		|| (paddr == drive_pkg::OFF_INT_MASK) || (paddr == drive_pkg::OFF_SEQ_STATUS);

	// read data is prepared in the setup cycle so prdata comes from a flop
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h0000_0000;
		end else begin
			pready  <= setup;
			pslverr <= setup && !mapped;
			if (setup && !pwrite) begin
				case (paddr)
					drive_pkg::OFF_CMD_WORD:    prdata <= {16'h0000, cmdWord_q};
					drive_pkg::OFF_CMD_EN:      prdata <= {31'h0000_0000, cmdEn_q};
					drive_pkg::OFF_SEQ_PARAMS:  prdata <= {23'h00_0000, seqParams_q};
					drive_pkg::OFF_EVENT_FLAGS: prdata <= {16'h0000, flags_q};
					drive_pkg::OFF_INT_MASK:    prdata <= {16'h0000, mask_q};
					drive_pkg::OFF_SEQ_STATUS:  prdata <= {16'h0000, seqStatus};
					default:                    prdata <= 32'h0000_0000;
				endcase
			end
		end
	end

	// top and reserved bits never stored
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			cmdWord_q <= drive_pkg::CMD_WORD_RST;
		end else if (wrAcc && paddr == drive_pkg::OFF_CMD_WORD) begin
			cmdWord_q <= pwdata[15:0] & drive_pkg::CW_STORE_MASK;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			cmdEn_q <= 1'b0;
			mask_q  <= 16'h0000;
		end else if (wrAcc) begin
			if (paddr == drive_pkg::OFF_CMD_EN) cmdEn_q <= pwdata[0];
			if (paddr == drive_pkg::OFF_INT_MASK) mask_q <= pwdata[15:0];
		end
	end

	// only software changes the individual parameters
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			seqParams_q <= drive_pkg::SP_RST;
		end else if (wrAcc && paddr == drive_pkg::OFF_SEQ_PARAMS) begin
			seqParams_q <= pwdata[drive_pkg::SP_W-1:0];
		end
	end

	// ************************************************
	// event flags
	// ************************************************
	logic defaultsDone;
	logic modeDone;

	event_arm u_defaults_evt (
		.clk       (sys_clk),
		.rstN      (rstN),
		.startEvt  (defaultsLoaded),
		.saveDone  (paramSaveDone),
		.donePulse (defaultsDone)
	);

	event_arm u_mode_evt (
		.clk       (sys_clk),
		.rstN      (rstN),
		.startEvt  (modeChanged),
		.saveDone  (paramSaveDone),
		.donePulse (modeDone)
	);

	always_comb begin
		flagsSet = 16'h0000;
		flagsSet[drive_pkg::EF_DEFAULTS] = defaultsDone;
		flagsSet[drive_pkg::EF_MODE_CHG] = modeDone;
	end

	// sticky, write one to clear, set wins over clear
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			flags_q <= drive_pkg::FLAGS_RST;
		end else begin
			flags_q <= (flags_q & ~(flagsWr ? pwdata[15:0] : 16'h0000)) | flagsSet;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			irq <= 1'b0;
		end else begin
			irq <= |(flags_q & mask_q);
		end
	end

	// ************************************************
	// sampling
	// ************************************************
	logic [7:0]                 cmdLoS_q;
	logic [7:0]                 cmdHiS_q;
	logic                       enS_q;
	logic                       enBg_q;
	logic [drive_pkg::SP_W-1:0] parS_q;

	// low byte and parameters on the sequencing tick
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			cmdLoS_q <= 8'h00;
			enS_q    <= 1'b0;
			parS_q   <= drive_pkg::SP_RST;
		end else if (seqTick) begin
			cmdLoS_q <= cmdWord_q[7:0];
			enS_q    <= cmdEn_q;
			parS_q   <= seqParams_q;
		end
	end

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			cmdHiS_q <= 8'h00;
			enBg_q   <= 1'b0;
		end else if (bgTick) begin
			cmdHiS_q <= cmdWord_q[15:8];
			enBg_q   <= cmdEn_q;
		end
	end

	// ************************************************
	// source selection and latching
	// ************************************************
	logic regen;
	logic wordSeq;
	logic wordStar;
	logic srcDrive;
	logic srcRunFwd;
	logic srcJog;
	logic srcRunRev;
	logic srcDir;
	logic srcRun;
	logic srcNotStop;
	logic srcJogBack;
	logic latchEn;

	assign regen   = (driveMode == drive_pkg::MODE_REGEN);
	// word in control only with enable and auto bit
	assign wordSeq = enS_q && cmdLoS_q[drive_pkg::CW_AUTO];
	// starred bits fall back to the parameters in regen
	assign wordStar = wordSeq && !regen;
	assign latchEn  = parS_q[drive_pkg::SP_LATCH_EN];

	// bit mapping of the word onto the sequencer
	assign srcDrive   = wordSeq ? cmdLoS_q[drive_pkg::CW_DRIVE_EN] : parS_q[drive_pkg::SP_DRIVE_EN];
	assign srcRunFwd  = wordStar ? cmdLoS_q[drive_pkg::CW_RUN_FWD] : parS_q[drive_pkg::SP_RUN_FWD];
	assign srcJog     = wordStar ? cmdLoS_q[drive_pkg::CW_JOG] : parS_q[drive_pkg::SP_INCH];
	assign srcRunRev  = wordStar ? cmdLoS_q[drive_pkg::CW_RUN_REV] : parS_q[drive_pkg::SP_RUN_REV];
	assign srcDir     = wordStar ? cmdLoS_q[drive_pkg::CW_DIR_SEL] : parS_q[drive_pkg::SP_DIR_SEL];
	assign srcRun     = wordStar ? cmdLoS_q[drive_pkg::CW_RUN] : parS_q[drive_pkg::SP_RUN_REQ];
	assign srcNotStop = wordStar ? cmdLoS_q[drive_pkg::CW_NOT_STOP]
		: parS_q[drive_pkg::SP_KEEP_RUN];
	assign srcJogBack = wordStar ? cmdHiS_q[drive_pkg::CW_JOG_REV - 8]
		: parS_q[drive_pkg::SP_JOG_BACK];

	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			driveEnable <= 1'b0;
			jog         <= 1'b0;
			dirSelect   <= 1'b0;
			notStop     <= 1'b0;
			jogBackward <= 1'b0;
		end else if (seqTick) begin
			driveEnable <= srcDrive;
			jog         <= srcJog;
			dirSelect   <= srcDir;
			notStop     <= srcNotStop;
			jogBackward <= srcJogBack;
		end
	end

	// run latches held only while not-stop is one
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			runFwd     <= 1'b0;
			runRev     <= 1'b0;
			runRequest <= 1'b0;
		end else if (seqTick) begin
			runFwd     <= srcNotStop ? (srcRunFwd || (latchEn && runFwd)) : 1'b0;
			runRev     <= srcNotStop ? (srcRunRev || (latchEn && runRev)) : 1'b0;
			runRequest <= srcNotStop ? (srcRun || (latchEn && runRequest)) : 1'b0;
		end
	end

	// reference select only follows the word, bit 7 plays no part
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			refSelect <= 1'b0;
		end else if (bgTick && enBg_q && !regen) begin
			refSelect <= cmdHiS_q[drive_pkg::CW_REF_SEL - 8];
		end
	end

	// ************************************************
	// limit switches
	// ************************************************
	logic signed [REF_W:0] refSum;
	logic signed [REF_W:0] limRef;

	assign refSum = {preRampRef[REF_W-1], preRampRef} + {hardSpeedRef[REF_W-1], hardSpeedRef};
	// open loop uses the pre-ramp reference alone
	assign limRef = (driveMode == drive_pkg::MODE_OPEN_LOOP)
		? {preRampRef[REF_W-1], preRampRef} : refSum;

	// zero reference enables both; regen has no direction, both enabled
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			fwdLimitEnable <= 1'b1;
			revLimitEnable <= 1'b1;
		end else begin
			fwdLimitEnable <= regen || !limRef[REF_W];
			revLimitEnable <= regen || limRef[REF_W] || (limRef == '0);
		end
	end

	// a switch stops only its own direction
	always_ff @(posedge sys_clk or negedge rstN) begin
		if (!rstN) begin
			fwdStop <= 1'b0;
			revStop <= 1'b0;
		end else begin
			fwdStop <= fwdLimitSwitch && fwdLimitEnable;
			revStop <= revLimitSwitch && revLimitEnable;
		end
	end

	assign seqStatus = {3'h0, fwdStop, revStop, fwdLimitEnable, revLimitEnable, refSelect,
		jogBackward, notStop, runRequest, runRev, dirSelect, jog, runFwd, driveEnable};

	// ************************************************
	// assertions
	// ************************************************
	a_cmd_top_zero: assert property (cmdWord_q[15] == 1'b0)
		else $error("command word top bit set");
	a_reserved_zero: assert property (cmdWord_q[11:10] == 2'b00)
		else $error("reserved command bits stored");
	a_flags_sticky: assert property (!$past(flagsWr) |-> &(flags_q | ~$past(flags_q)))
		else $error("event flag dropped without software clear");
	a_flag_defaults: assert property (defaultsDone |=> flags_q[drive_pkg::EF_DEFAULTS])
		else $error("defaults flag not set");
	a_flag_mode: assert property (modeDone |=> flags_q[drive_pkg::EF_MODE_CHG])
		else $error("mode change flag not set");
	a_cl_limits: assert property ($past(driveMode) == drive_pkg::MODE_CLOSED_LOOP
		&& $past(refSum) > 0 |-> fwdLimitEnable && !revLimitEnable)
		else $error("closed loop positive reference limit wrong");
	a_ol_limits: assert property ($past(driveMode) == drive_pkg::MODE_OPEN_LOOP
		&& $past(preRampRef) < 0 |-> !fwdLimitEnable && revLimitEnable)
		else $error("open loop negative reference limit wrong");
	a_zero_limits: assert property ($past(driveMode) != drive_pkg::MODE_OPEN_LOOP
		&& $past(refSum) == 0 |-> fwdLimitEnable && revLimitEnable)
		else $error("zero reference must enable both limits");
	a_word_ignored: assert property (seqTick && !wordSeq |=>
		driveEnable == $past(parS_q[drive_pkg::SP_DRIVE_EN]))
		else $error("drive enable not from parameter");
	a_word_drives: assert property (seqTick && wordSeq |=>
		driveEnable == $past(cmdLoS_q[drive_pkg::CW_DRIVE_EN]))
		else $error("drive enable not from command word");
	a_regen_jog: assert property (seqTick && regen |=> jog == $past(parS_q[drive_pkg::SP_INCH]))
		else $error("regen mode took jog from word");
	a_notstop_clear: assert property (seqTick && !srcNotStop |=> !runFwd && !runRev && !runRequest)
		else $error("run latch kept while not-stop low");
	a_lo_sampling: assert property (!$past(seqTick) |-> $stable(cmdLoS_q) && $stable(parS_q))
		else $error("low byte sampled off the tick");
	a_params_kept: assert property (!$past(wrAcc) |-> $stable(seqParams_q))
		else $error("individual parameters changed by hardware");
	a_stop_own_dir: assert property (fwdStop |-> $past(fwdLimitSwitch) && $past(fwdLimitEnable))
		else $error("forward stop without its switch");
	a_irq_level: assert property (irq == $past(|(flags_q & mask_q)))
		else $error("interrupt does not follow masked flags");

	c_word_control: cover property (seqTick && wordSeq);
	c_defaults_flag: cover property ($rose(flags_q[drive_pkg::EF_DEFAULTS]));
	c_flag_cleared: cover property ($fell(flags_q[drive_pkg::EF_MODE_CHG]));
	c_fwd_stop: cover property (fwdStop);
endmodule // drive_seq_sources

//--- logic/event_arm.sv
// arms on a start event and reports completion at the next save done
`timescale 1ns/1ns
module event_arm (
	// clock and reset
	input  wire logic clk,
	input  wire logic rstN,
	// events
	input  wire logic startEvt,
	input  wire logic saveDone,
	// result
	output logic      donePulse
);
	logic armed_q;

	// a save seen while armed completes the event; a new start re-arms
	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			armed_q <= 1'b0;
		end else if (startEvt) begin
			armed_q <= 1'b1;
		end else if (saveDone) begin
			armed_q <= 1'b0;
		end
	end

	always_ff @(posedge clk or negedge rstN) begin
		if (!rstN) begin
			donePulse <= 1'b0;
		end else begin
			donePulse <= armed_q && saveDone;
		end
	end

	a_done_needs_arm: assert property (@(posedge clk) disable iff (!rstN)
		donePulse |-> $past(armed_q) && $past(saveDone))
		else $error("completion without armed start");
endmodule // event_arm

//--- tb/apb_host.sv
// apb host model standing in for the software side of the register bus
`timescale 1ns/1ns
module apb_host (
	// clock
	input  wire logic        sys_clk,
	// apb master side
	output logic             psel,
	output logic             penable,
	output logic             pwrite,
	output logic [7:0]       paddr,
	output logic [31:0]      pwdata,
	input  wire logic [31:0] prdata,
	input  wire logic        pready,
	input  wire logic        pslverr
);
	initial begin
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 8'h00;
		pwdata = 32'h00000000;
	end

	// one transfer; request held until pready is seen, ok low on a hang
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] r, output logic err, output logic ok);
		int i;
		ok = 1'b0;
		r = 32'h00000000;
		err = 1'b0;
		@(posedge sys_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge sys_clk);
		penable <= 1'b1;
		for (i = 0; i < 16 && !ok; i++) begin
			@(posedge sys_clk);
			if (pready === 1'b1) begin
				ok = 1'b1;
				r = prdata;
				err = pslverr;
			end
		end
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
endmodule // apb_host

//--- tb/test_drive_control_word_sequencer.sv
// self-checking bench for the sequencer source selection block
`timescale 1ns/1ns
module test_drive_control_word_sequencer;
	localparam int SETTLE = 30;
	logic                   sys_clk;
	logic                   resetn;
	logic                   psel, penable, pwrite, pready, pslverr, irq;
	logic [7:0]             paddr;
	logic [31:0]            pwdata, prdata, rdData;
	drive_pkg::drive_mode_t driveMode;
	logic signed [31:0]     preRampRef, hardSpeedRef;
	logic                   fwdLimitSwitch, revLimitSwitch;
	logic                   defaultsLoaded, modeChanged, paramSaveDone;
	logic                   driveEnable, runFwd, jog, runRev, dirSelect;
	logic                   runRequest, notStop, jogBackward, refSelect;
	logic                   fwdLimitEnable, revLimitEnable, fwdStop, revStop;
	logic                   lastErr, okFlag;
	int                     numErrors, nTests;

	// short ticks keep the run brief
	drive_seq_sources #(.SEQ_TICK_CYCLES(8), .BG_TICK_CYCLES(5), .REF_W(32)) u_dut (
		.sys_clk, .resetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .irq, .driveMode, .preRampRef, .hardSpeedRef,
		.fwdLimitSwitch, .revLimitSwitch, .defaultsLoaded, .modeChanged,
		.paramSaveDone, .driveEnable, .runFwd, .jog, .runRev, .dirSelect,
		.runRequest, .notStop, .jogBackward, .refSelect, .fwdLimitEnable,
		.revLimitEnable, .fwdStop, .revStop);
	apb_host u_host (.sys_clk, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr);

	always #10 sys_clk = ~sys_clk;

	// ************************************************
	// helpers
	// ************************************************
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", nTests, numErrors);
		if (numErrors == 0 && nTests > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		nTests++;
		if (got !== exp) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
			numErrors++;
		end
	endtask
	task automatic rw(input logic w, input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(w, a, d, rdData, lastErr, okFlag);
		if (okFlag !== 1'b1) begin
			$display("CHECK FAILED t=%0t got=%h exp=%h", $time, 1'b0, 1'b1);
			numErrors++;
			report_and_stop();
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		rw(1'b1, a, d);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		rw(1'b0, a, 32'h00000000);
		chk(rdData, exp);
	endtask
	function automatic logic [31:0] seqOut();
		return {23'h000000, refSelect, jogBackward, notStop, runRequest,
			dirSelect, runRev, jog, runFwd, driveEnable};
	endfunction
	// start pulse, then the save one cycle later
	task automatic fire(input logic modeEvt);
		@(posedge sys_clk);
		defaultsLoaded <= !modeEvt;
		modeChanged <= modeEvt;
		@(posedge sys_clk);
		defaultsLoaded <= 1'b0;
		modeChanged <= 1'b0;
		paramSaveDone <= 1'b1;
		@(posedge sys_clk);
		paramSaveDone <= 1'b0;
		repeat (4) @(posedge sys_clk);
	endtask

	// ************************************************
	// scenarios
	// ************************************************
	task automatic tRegs();
		rd(drive_pkg::OFF_CMD_WORD, 32'h00000000);
		rd(drive_pkg::OFF_CMD_EN, 32'h00000000);
		rd(drive_pkg::OFF_SEQ_PARAMS, 32'h00000000);
		rd(drive_pkg::OFF_EVENT_FLAGS, 32'h00000000);
		rd(drive_pkg::OFF_SEQ_STATUS, 32'h00000600);
		rw(1'b0, 8'h40, 32'h00000000);
		chk(lastErr, 1'b1);
		chk(rdData, 32'h00000000);
		wr(drive_pkg::OFF_CMD_WORD, 32'h0000FFFF);
		rd(drive_pkg::OFF_CMD_WORD, 32'h000073FF);
		wr(drive_pkg::OFF_CMD_WORD, 32'h00000000);
		$display("register test done");
	endtask
	task automatic tEvents();
		wr(drive_pkg::OFF_INT_MASK, 32'h00000001);
		fire(1'b1);
		chk(irq, 1'b0);
		rd(drive_pkg::OFF_EVENT_FLAGS, 32'h00000002);
		fire(1'b0);
		chk(irq, 1'b1);
		rd(drive_pkg::OFF_EVENT_FLAGS, 32'h00000003);
		repeat (40) @(posedge sys_clk);
		rd(drive_pkg::OFF_EVENT_FLAGS, 32'h00000003);
		wr(drive_pkg::OFF_EVENT_FLAGS, 32'h00000001);
		rd(drive_pkg::OFF_EVENT_FLAGS, 32'h00000002);
		chk(irq, 1'b0);
		wr(drive_pkg::OFF_EVENT_FLAGS, 32'h00000002);
		rd(drive_pkg::OFF_EVENT_FLAGS, 32'h00000000);
		$display("event test done");
	endtask
	task automatic tSeq();
		driveMode <= drive_pkg::MODE_CLOSED_LOOP;
		wr(drive_pkg::OFF_SEQ_PARAMS, 32'h00000001);
		wr(drive_pkg::OFF_CMD_WORD, 32'h000003FE);
		repeat (SETTLE) @(posedge sys_clk);
		chk(seqOut(), 32'h00000001);
		wr(drive_pkg::OFF_CMD_EN, 32'h00000001);
		repeat (SETTLE) @(posedge sys_clk);
		chk(seqOut(), 32'h000001FE);
		rd(drive_pkg::OFF_SEQ_PARAMS, 32'h00000001);
		wr(drive_pkg::OFF_CMD_WORD, 32'h0000037E);
		repeat (SETTLE) @(posedge sys_clk);
		chk(seqOut(), 32'h00000101);
		driveMode <= drive_pkg::MODE_REGEN;
		wr(drive_pkg::OFF_CMD_WORD, 32'h000003FE);
		repeat (SETTLE) @(posedge sys_clk);
		chk(seqOut() & 32'h000000FF, 32'h00000000);
		driveMode <= drive_pkg::MODE_CLOSED_LOOP;
		wr(drive_pkg::OFF_CMD_EN, 32'h00000000);
		$display("sequencer test done");
	endtask
	task automatic tLatch();
		wr(drive_pkg::OFF_SEQ_PARAMS, 32'h00000143);
		repeat (SETTLE) @(posedge sys_clk);
		chk(runFwd, 1'b1);
		wr(drive_pkg::OFF_SEQ_PARAMS, 32'h00000141);
		repeat (SETTLE) @(posedge sys_clk);
		chk(runFwd, 1'b1);
		wr(drive_pkg::OFF_SEQ_PARAMS, 32'h00000101);
		repeat (SETTLE) @(posedge sys_clk);
		chk({runFwd, notStop}, 2'b00);
		wr(drive_pkg::OFF_SEQ_PARAMS, 32'h000000C1);
		repeat (SETTLE) @(posedge sys_clk);
		chk({jogBackward, runFwd, notStop}, 3'b101);
		$display("latch test done");
	endtask
	task automatic tLimits();
		driveMode <= drive_pkg::MODE_OPEN_LOOP;
		preRampRef <= 32'sd5;
		hardSpeedRef <= -32'sd10;
		repeat (4) @(posedge sys_clk);
		chk({fwdLimitEnable, revLimitEnable}, 2'b10);
		preRampRef <= -32'sd5;
		repeat (4) @(posedge sys_clk);
		chk({fwdLimitEnable, revLimitEnable}, 2'b01);
		preRampRef <= 32'sd5;
		driveMode <= drive_pkg::MODE_SERVO;
		repeat (4) @(posedge sys_clk);
		chk({fwdLimitEnable, revLimitEnable}, 2'b01);
		driveMode <= drive_pkg::MODE_CLOSED_LOOP;
		repeat (4) @(posedge sys_clk);
		chk({fwdLimitEnable, revLimitEnable}, 2'b01);
		hardSpeedRef <= -32'sd5;
		repeat (4) @(posedge sys_clk);
		chk({fwdLimitEnable, revLimitEnable}, 2'b11);
		hardSpeedRef <= 32'sd0;
		fwdLimitSwitch <= 1'b1;
		revLimitSwitch <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk({fwdStop, revStop}, 2'b10);
		$display("limit test done");
	endtask

	// ************************************************
	// main sequence
	// ************************************************
	initial begin
		sys_clk = 1'b0;
		resetn = 1'b0;
		driveMode = drive_pkg::MODE_OPEN_LOOP;
		preRampRef = 32'sd0;
		hardSpeedRef = 32'sd0;
		{fwdLimitSwitch, revLimitSwitch} = 2'b00;
		{defaultsLoaded, modeChanged, paramSaveDone} = 3'b000;
		numErrors = 0;
		nTests = 0;
		repeat (12) @(posedge sys_clk);
		resetn <= 1'b1;
		repeat (3) @(posedge sys_clk);
		tRegs();
		tEvents();
		tSeq();
		tLatch();
		tLimits();
		report_and_stop();
	end
endmodule // test_drive_control_word_sequencer
